// *** logic/st_cfg.svh ***
/*
 Constants for the pressure chain self-test block: register offsets,
 field positions, reset values, selection codes, forced words and times.
 Assumes inclusion by bare name from the top module and the testbench top.
*/
`ifndef ST_CFG_SVH
`define ST_CFG_SVH
// Register byte offsets
`define OFS_CFG5 8'h00
`define OFS_CTRL 8'h04
`define OFS_STAT 8'h08
`define OFS_IRQ_STAT 8'h0c
`define OFS_IRQ_MASK 8'h10
// Field positions
`define SEL_HI 3
`define SEL_LO 0
`define KIND_LO 4
`define CTRL_LOCK 0
`define CTRL_PSI5 1
`define CTRL_RPT_LO 4
`define CTRL_RPT_HI 7
`define IRQ_DONE 0
`define IRQ_FAIL 1
// Reset values
`define RST_RPT 4'h3
`define RST_KIND 2'h3
// Selection codes
`define CODE_NORMAL 4'h0
`define CODE_CM 4'h1
`define CODE_FIX_LO 2'h1
`define CODE_DIG_HI 2'h3
// Forced words
`define DIG1_ABS 16'h8171
`define DIG2_ABS 16'h6c95
`define DIG3_ABS 16'h807a
`define DIG4_ABS 16'h78ac
`define DIG_REL 16'h8001
`define FIX1 16'h0000
`define FIX2 16'haaaa
`define FIX3 16'h5555
`define FIX4 16'hffff
// Times in microseconds and clock rate
`define CLK_MHZ 10
`define T_ITER_US 1000
`define T_START_US 2000
`define T_BASE_US 1000
`endif

// *** logic/st_pkg.sv ***
/*
 Types for the pressure chain self-test block.
 Assumes st_cfg.svh is reachable on the include path.
*/
package st_pkg;
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } ahb_req_t;
    typedef struct packed {
        logic [15:0] ch1;
        logic [15:0] ch0;
    } sense_pair_t;
    typedef enum logic [4:0] {
        AUTO_WAIT = 5'b00001,
        AUTO_RUN = 5'b00010,
        AUTO_BASE = 5'b00100,
        AUTO_DONE = 5'b01000,
        AUTO_OFF = 5'b10000
    } auto_state_t;
endpackage

// *** logic/pressure_chain_self_test.sv ***
/*
 Self-test controller for a pressure sensor signal chain, with an AHB-Lite
 register slave, an interrupt output and two sensor output channels.
 Assumes one clock hclk at 10 MHz, asynchronous active-low hresetn, inputs
 synchronous to hclk, and a single master seeing hreadyout as hready.
*/
`timescale 1ns/1ns
`default_nettype none
`include "st_cfg.svh"
module pressure_chain_self_test #(
    parameter int ITER_CYC = `T_ITER_US * `CLK_MHZ,
    parameter int START_CYC = `T_START_US * `CLK_MHZ,
    parameter int BASE_CYC = `T_BASE_US * `CLK_MHZ
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    input wire logic [15:0] dsp_abs_word,
    input wire logic [15:0] dsp_rel_word,
    input wire logic dsp_valid,
    input wire logic cm_exceed,
    output st_pkg::sense_pair_t sensor_output_word,
    output logic [1:0] filter_force_sel,
    output logic filter_force,
    output logic cm_measure,
    output logic error_message,
    output logic baseline_filter_init
);
    import st_pkg::*;

    // Bus and register state
    ahb_req_t req, next_req;
    logic [3:0] test_select, next_test_select;
    logic [1:0] output_kind_select, next_output_kind_select;
    logic init_done_lock, next_init_done_lock;
    logic psi5_mode, next_psi5_mode;
    logic [3:0] retry_limit, next_retry_limit;
    logic [1:0] irq_stat, next_irq_stat;
    logic [1:0] irq_mask, next_irq_mask;
    logic [31:0] next_hrdata;
    logic next_irq;

    // Test state
    logic cm_running, next_cm_running;
    logic [15:0] cm_tmr, next_cm_tmr;
    logic test_fail_flag, next_test_fail_flag;
    logic fail_locked, next_fail_locked;
    auto_state_t auto_st, next_auto_st;
    logic [15:0] auto_tmr, next_auto_tmr;
    logic [3:0] tries, next_tries;
    logic auto_running;
    logic test_running_flag;
    logic was_running;
    logic [1:0] events;
    sense_pair_t next_sensor;
    logic [1:0] next_force_sel;
    logic next_force, next_cm_measure, next_err, next_base;

    logic wr_en;
    logic [3:0] wsel;

    function automatic logic is_fixed(input logic [3:0] c);
        return c[3:2] == `CODE_FIX_LO;
    endfunction

    function automatic logic is_dig(input logic [3:0] c);
        return c[3:2] == `CODE_DIG_HI;
    endfunction

    function automatic logic [15:0] dig_abs(input logic [1:0] i);
        case (i)
            2'h0: return `DIG1_ABS;
            2'h1: return `DIG2_ABS;
            2'h2: return `DIG3_ABS;
            default: return `DIG4_ABS;
        endcase
    endfunction

    function automatic logic [15:0] fix_word(input logic [1:0] i);
        case (i)
            2'h0: return `FIX1;
            2'h1: return `FIX2;
            2'h2: return `FIX3;
            default: return `FIX4;
        endcase
    endfunction

    assign auto_running = (auto_st == AUTO_RUN) || (auto_st == AUTO_WAIT && psi5_mode);
    assign test_running_flag = cm_running || auto_running
        || is_dig(test_select) || is_fixed(test_select);
    assign wr_en = req.valid && req.write;
    assign wsel = hwdata[`SEL_HI:`SEL_LO];

    // Bus slave and registers
    always_comb begin
        next_req.valid = hsel && htrans[1] && hready;
        next_req.write = hwrite;
        next_req.addr = haddr[7:0];
        next_test_select = test_select;
        next_output_kind_select = output_kind_select;
        next_init_done_lock = init_done_lock;
        next_psi5_mode = psi5_mode;
        next_retry_limit = retry_limit;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_hrdata = 32'h0;
        if (wr_en && req.addr == `OFS_CFG5) begin
            if (!init_done_lock) begin
                next_test_select = wsel;
            end
            next_output_kind_select = hwdata[`KIND_LO+1:`KIND_LO];
        end else if (wr_en && req.addr == `OFS_CTRL) begin
            next_init_done_lock = init_done_lock | hwdata[`CTRL_LOCK];
            next_psi5_mode = hwdata[`CTRL_PSI5];
            next_retry_limit = hwdata[`CTRL_RPT_HI:`CTRL_RPT_LO];
        end else if (wr_en && req.addr == `OFS_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~hwdata[1:0];
        end else if (wr_en && req.addr == `OFS_IRQ_MASK) begin
            next_irq_mask = hwdata[1:0];
        end
        if (next_init_done_lock) begin
            next_test_select = `CODE_NORMAL;
        end
        // Event set wins over a same-cycle clear
        next_irq_stat = next_irq_stat | events;
        if (next_req.valid && !hwrite) begin
            // Next values, so a read right behind a write returns the new word
            if (haddr[7:0] == `OFS_CFG5) begin
                next_hrdata[`SEL_HI:`SEL_LO] = next_test_select;
                next_hrdata[`KIND_LO+1:`KIND_LO] = next_output_kind_select;
            end else if (haddr[7:0] == `OFS_CTRL) begin
                next_hrdata[`CTRL_LOCK] = next_init_done_lock;
                next_hrdata[`CTRL_PSI5] = next_psi5_mode;
                next_hrdata[`CTRL_RPT_HI:`CTRL_RPT_LO] = next_retry_limit;
            end else if (haddr[7:0] == `OFS_STAT) begin
                next_hrdata[4:0] = {baseline_filter_init, error_message,
                    auto_st == AUTO_DONE, test_fail_flag, test_running_flag};
            end else if (haddr[7:0] == `OFS_IRQ_STAT) begin
                next_hrdata[1:0] = next_irq_stat;
            end else if (haddr[7:0] == `OFS_IRQ_MASK) begin
                next_hrdata[1:0] = next_irq_mask;
            end
        end
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
            test_select <= `CODE_NORMAL;
            output_kind_select <= `RST_KIND;
            init_done_lock <= 1'b0;
            psi5_mode <= 1'b0;
            retry_limit <= `RST_RPT;
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            irq <= 1'b0;
        end else if (ce) begin
            req <= next_req;
            test_select <= next_test_select;
            output_kind_select <= next_output_kind_select;
            init_done_lock <= next_init_done_lock;
            psi5_mode <= next_psi5_mode;
            retry_limit <= next_retry_limit;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            irq <= next_irq;
        end
    end

    // Manual common-mode test and fail flag
    always_comb begin
        next_cm_running = cm_running;
        next_cm_tmr = cm_tmr;
        next_test_fail_flag = test_fail_flag;
        next_fail_locked = fail_locked;
        if (!cm_running && test_select == `CODE_CM && !auto_running) begin
            next_cm_running = 1'b1;
            next_cm_tmr = 16'(ITER_CYC - 1);
            if (!fail_locked) begin
                next_test_fail_flag = 1'b0;
            end
        end else if (cm_running && cm_tmr != 16'h0) begin
            next_cm_tmr = cm_tmr - 16'h1;
        end else if (cm_running) begin
            next_test_fail_flag = cm_exceed | fail_locked;
            if (test_select == `CODE_CM) begin
                next_cm_tmr = 16'(ITER_CYC - 1);
            end else begin
                next_cm_running = 1'b0;
            end
        end
        if (auto_st == AUTO_RUN && auto_tmr == 16'h0) begin
            if (!(cm_exceed || dsp_abs_word != `DIG1_ABS)) begin
                next_test_fail_flag = 1'b0;
            end else if (tries >= retry_limit) begin
                next_test_fail_flag = 1'b1;
                next_fail_locked = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cm_running <= 1'b0;
            cm_tmr <= 16'h0;
            test_fail_flag <= 1'b0;
            fail_locked <= 1'b0;
        end else if (ce) begin
            cm_running <= next_cm_running;
            cm_tmr <= next_cm_tmr;
            test_fail_flag <= next_test_fail_flag;
            fail_locked <= next_fail_locked;
        end
    end

    // Automatic PSI5 startup test
    always_comb begin
        next_auto_st = auto_st;
        next_auto_tmr = auto_tmr;
        next_tries = tries;
        case (auto_st)
            AUTO_WAIT: begin
                if (auto_tmr != 16'h0) begin
                    next_auto_tmr = auto_tmr - 16'h1;
                end else if (psi5_mode) begin
                    next_auto_st = AUTO_RUN;
                    next_auto_tmr = 16'(ITER_CYC - 1);
                    next_tries = 4'h0;
                end else begin
                    next_auto_st = AUTO_OFF;
                end
            end
            AUTO_RUN: begin
                if (auto_tmr != 16'h0) begin
                    next_auto_tmr = auto_tmr - 16'h1;
                end else if ((cm_exceed || dsp_abs_word != `DIG1_ABS)
                        && tries < retry_limit) begin
                    next_tries = tries + 4'h1;
                    next_auto_tmr = 16'(ITER_CYC - 1);
                end else begin
                    next_auto_st = AUTO_BASE;
                    next_auto_tmr = 16'(BASE_CYC - 1);
                end
            end
            AUTO_BASE: begin
                if (auto_tmr != 16'h0) begin
                    next_auto_tmr = auto_tmr - 16'h1;
                end else begin
                    next_auto_st = AUTO_DONE;
                end
            end
            default: begin
                next_auto_st = auto_st;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            auto_st <= AUTO_WAIT;
            auto_tmr <= 16'(START_CYC - 1);
            tries <= 4'h0;
        end else if (ce) begin
            auto_st <= next_auto_st;
            auto_tmr <= next_auto_tmr;
            tries <= next_tries;
        end
    end

    // Output words, forcing and events
    always_comb begin
        next_sensor = sensor_output_word;
        next_force_sel = test_select[1:0];
        next_force = is_dig(test_select);
        next_cm_measure = cm_running || auto_st == AUTO_RUN;
        next_err = fail_locked;
        next_base = auto_st == AUTO_BASE;
        events[`IRQ_DONE] = was_running && !test_running_flag;
        events[`IRQ_FAIL] = next_test_fail_flag && !test_fail_flag;
        if (auto_st == AUTO_RUN) begin
            next_force_sel = 2'h0;
            next_force = 1'b1;
        end
        if (is_fixed(test_select)) begin
            next_sensor.ch0 = fix_word(test_select[1:0]);
            next_sensor.ch1 = fix_word(test_select[1:0]);
        end else if (is_dig(test_select)) begin
            next_sensor.ch0 = output_kind_select[0]
                ? dig_abs(test_select[1:0]) : `DIG_REL;
            next_sensor.ch1 = output_kind_select[1]
                ? dig_abs(test_select[1:0]) : `DIG_REL;
        end else if (dsp_valid) begin
            next_sensor.ch0 = output_kind_select[0] ? dsp_abs_word : dsp_rel_word;
            next_sensor.ch1 = output_kind_select[1] ? dsp_abs_word : dsp_rel_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sensor_output_word <= '0;
            filter_force_sel <= 2'h0;
            filter_force <= 1'b0;
            cm_measure <= 1'b0;
            error_message <= 1'b0;
            baseline_filter_init <= 1'b0;
            was_running <= 1'b0;
        end else if (ce) begin
            sensor_output_word <= next_sensor;
            filter_force_sel <= next_force_sel;
            filter_force <= next_force;
            cm_measure <= next_cm_measure;
            error_message <= next_err;
            baseline_filter_init <= next_base;
            was_running <= test_running_flag;
        end
    end
endmodule
`default_nettype wire

// *** sim/pressure_chain_self_test_checker.sv ***
/* Port checker for pressure_chain_self_test.
   Bound from the testbench top; ce is assumed held high. */
`timescale 1ns/1ns
`default_nettype none
module pressure_chain_self_test_checker #(
    parameter int START_CYC = 50,
    parameter int BASE_CYC = 20
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic error_message,
    input wire logic baseline_filter_init
);
    localparam int BASE_MAX = BASE_CYC + 2;
    int since;
    // Cycles since reset release, saturating at the start delay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since <= 0;
        end else if (since < START_CYC) begin
            since <= since + 1;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("hresp not OKAY");
    property p_ready;
        $past(hresetn) |-> hreadyout;
    endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    property p_err_sticky;
        error_message |=> error_message;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error message dropped");
    property p_err_late;
        error_message |-> since >= START_CYC;
    endproperty
    a_err_late: assert property (p_err_late) else $error("error before start");
    property p_base_late;
        baseline_filter_init |-> since >= START_CYC;
    endproperty
    a_base_late: assert property (p_base_late) else $error("baseline init early");
    property p_base_hold;
        $rose(baseline_filter_init) |=> baseline_filter_init [*8];
    endproperty
    a_base_hold: assert property (p_base_hold) else $error("baseline init short");
    property p_base_end;
        $rose(baseline_filter_init) |-> ##[1:BASE_MAX] !baseline_filter_init;
    endproperty
    a_base_end: assert property (p_base_end) else $error("baseline init long");
    property p_base_once;
        $fell(baseline_filter_init) |=> !baseline_filter_init [*8];
    endproperty
    a_base_once: assert property (p_base_once) else $error("baseline init again");
endmodule
`default_nettype wire

// *** sim/pressure_chain_self_test_tb_top.sv ***
/* Testbench for pressure_chain_self_test: AHB-Lite master tasks, one task
   per scenario. Assumes shortened counts and the checker bound below. */
`timescale 1ns/1ns
`default_nettype none
`include "st_cfg.svh"
module pressure_chain_self_test_tb_top;
    import st_pkg::*;
    localparam int IT = 20;
    localparam int ST = 50;
    localparam int BS = 20;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, dsp_valid = 1'b0, cm_exceed = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [15:0] dsp_abs_word = 16'h0, dsp_rel_word = 16'h0;
    logic hreadyout, hresp, irq, filter_force, cm_measure, error_message, bfi;
    logic [1:0] filter_force_sel;
    sense_pair_t sensor_output_word;
    int miscompares = 0, checks = 0, cyc = 0;
    logic [15:0] fx [4] = '{`FIX1, `FIX2, `FIX3, `FIX4};
    logic [15:0] dg [4] = '{`DIG1_ABS, `DIG2_ABS, `DIG3_ABS, `DIG4_ABS};
    pressure_chain_self_test #(.ITER_CYC(IT), .START_CYC(ST), .BASE_CYC(BS)) i_pressure_chain_self_test (
        .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .irq(irq), .dsp_abs_word(dsp_abs_word), .dsp_rel_word(dsp_rel_word),
        .dsp_valid(dsp_valid), .cm_exceed(cm_exceed),
        .sensor_output_word(sensor_output_word), .filter_force_sel(filter_force_sel),
        .filter_force(filter_force), .cm_measure(cm_measure),
        .error_message(error_message), .baseline_filter_init(bfi)
    );
    initial begin
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= hresetn ? cyc + 1 : 0;
    end
    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // Single AHB transfer; entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic pulse(input logic [15:0] a, input logic [15:0] r);
        dsp_abs_word <= a;
        dsp_rel_word <= r;
        dsp_valid <= 1'b1;
        tick(1);
        dsp_valid <= 1'b0;
        tick(2);
    endtask
    task automatic do_reset;
        hresetn <= 1'b0;
        tick(8);
        hresetn <= 1'b1;
        tick(1);
    endtask
    task automatic wait_bfi(input logic v, output int n);
        n = 0;
        while (bfi !== v && n < 500) begin
            tick(1);
            n++;
        end
    endtask
    task automatic t_reset;
        xfer(0, `OFS_CFG5, 0);
        chk("cfg5", 32'h30, rd);
        xfer(0, `OFS_CTRL, 0);
        chk("ctrl", 32'h30, rd);
        xfer(0, `OFS_STAT, 0);
        chk("stat", 32'h0, rd);
        xfer(0, 8'h14, 0);
        chk("unmapped", 32'h0, rd);
    endtask
    task automatic t_normal;
        pulse(16'h1234, 16'h5678);
        chk("words", 32'h12341234, sensor_output_word);
        xfer(1, `OFS_CFG5, 32'h10);
        pulse(16'h1234, 16'h5678);
        chk("words", 32'h56781234, sensor_output_word);
        chk("force", 32'h0, 32'(filter_force));
    endtask
    task automatic t_codes;
        for (int j = 0; j < 8; j++) begin
            xfer(1, `OFS_CFG5, 32'h10 | (j < 4 ? 4 + j : 8 + j));
            pulse(16'h1357, 16'h2468);
            chk("words", j < 4 ? {fx[j], fx[j]} : {`DIG_REL, dg[j - 4]},
                sensor_output_word);
            if (j >= 4) chk("sel", 32'(j - 4), 32'({filter_force, filter_force_sel}) - 4);
            xfer(0, `OFS_STAT, 0);
            chk("running", 32'h1, 32'(rd[0]));
        end
    endtask
    task automatic t_cm;
        cm_exceed <= 1'b1;
        xfer(1, `OFS_CFG5, 32'h31);
        // Running rises one cycle after the selection lands
        tick(1);
        xfer(0, `OFS_STAT, 0);
        chk("cm start", 32'h1, 32'(rd[1:0]));
        chk("measure", 32'h1, 32'(cm_measure));
        tick(IT + 2);
        xfer(0, `OFS_STAT, 0);
        chk("cm fail", 32'h3, 32'(rd[1:0]));
        cm_exceed <= 1'b0;
        tick(IT + 2);
        xfer(0, `OFS_STAT, 0);
        chk("cm repeat", 32'h1, 32'(rd[1:0]));
        cm_exceed <= 1'b1;
        xfer(1, `OFS_CFG5, 32'h30);
        xfer(0, `OFS_STAT, 0);
        chk("cm hold", 32'h1, 32'(rd[0]));
        tick(IT + 2);
        xfer(0, `OFS_STAT, 0);
        chk("cm final", 32'h2, 32'(rd[1:0]));
        chk("measure", 32'h0, 32'(cm_measure));
        xfer(0, `OFS_IRQ_STAT, 0);
        chk("irq stat", 32'h3, rd);
        xfer(1, `OFS_IRQ_MASK, 32'h1);
        tick(2);
        chk("irq on", 32'h1, 32'(irq));
        xfer(1, `OFS_IRQ_STAT, 32'h1);
        tick(2);
        chk("irq off", 32'h0, 32'(irq));
    endtask
    task automatic t_lock;
        xfer(1, `OFS_CFG5, 32'h34);
        xfer(1, `OFS_CTRL, 32'h31);
        xfer(0, `OFS_CFG5, 0);
        chk("locked sel", 32'h30, rd);
        xfer(1, `OFS_CFG5, 32'h3c);
        xfer(0, `OFS_CFG5, 0);
        chk("locked sel", 32'h30, rd);
        pulse(16'h1111, 16'h2222);
        chk("words", 32'h11111111, sensor_output_word);
    endtask
    task automatic t_auto(input logic [3:0] rpt, input logic bad, input int iters);
        int n;
        int e;
        do_reset();
        cm_exceed <= bad;
        dsp_abs_word <= `DIG1_ABS;
        xfer(1, `OFS_CTRL, {24'h0, rpt, 4'h2});
        xfer(0, `OFS_STAT, 0);
        chk("auto wait", 32'h1, 32'(rd[0]));
        // Past the start delay, inside the first iteration
        tick(ST);
        chk("auto force", 32'h4, 32'({filter_force, filter_force_sel}));
        chk("auto measure", 32'h1, 32'(cm_measure));
        wait_bfi(1'b1, n);
        e = ST + iters * IT;
        chk("auto len", 32'h1, 32'(cyc >= e - 2 && cyc <= e + 3));
        chk("err msg", 32'(bad), 32'(error_message));
        xfer(0, `OFS_STAT, 0);
        chk("auto stat", bad ? 32'h1a : 32'h10, 32'(rd[4:0]));
        wait_bfi(1'b0, n);
        chk("base len", 32'h1, 32'(n >= BS - 6 && n <= BS + 2));
        chk("err msg", 32'(bad), 32'(error_message));
        xfer(0, `OFS_STAT, 0);
        chk("auto done", bad ? 32'h0e : 32'h04, 32'(rd[4:0]));
    endtask
    initial begin
        do_reset();
        t_reset();
        t_normal();
        t_codes();
        t_cm();
        t_lock();
        t_auto(4'h1, 1'b1, 2);
        t_auto(4'h3, 1'b0, 1);
        tally_and_finish();
    end
    initial begin
        tick(3000);
        miscompares++;
        tally_and_finish();
    end
endmodule
bind pressure_chain_self_test pressure_chain_self_test_checker #(
    .START_CYC(START_CYC), .BASE_CYC(BASE_CYC)
) i_pressure_chain_self_test_checker (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .error_message(error_message), .baseline_filter_init(baseline_filter_init)
);
`default_nettype wire
